// ---- rtl/dpm_cfg.svh ----
// constants for the dual-port ram with burst counters and mailboxes
`ifndef DPM_CFG_SVH
`define DPM_CFG_SVH

`define DPM_ADDR_W 17
`define DPM_DATA_W 36
`define DPM_LANES 4
`define DPM_CNT_RST_VAL 1'b0
`define DPM_MASK_RST_VAL 1'b1
`define DPM_FLAG_RST_VAL 1'b1
`define DPM_MBOX_R_OFS 1
`define DPM_MBOX_L_OFS 2

`endif

// ---- rtl/dpm_pkg.sv ----
// types shared by the dual-port ram files
package dpm_pkg;

    typedef enum logic [2:0] {
        DPM_OP_HOLD,
        DPM_OP_CLEAR,
        DPM_OP_LOAD,
        DPM_OP_INC,
        DPM_OP_MASK_CLEAR,
        DPM_OP_MASK_LOAD
    } dpm_op_t;

endpackage

// ---- rtl/dpm_port.sv ----
// burst counter, mask register and wrap flag of one port
`timescale 1ns/100ps
`include "dpm_cfg.svh"

module dpm_port #(
    parameter int ADDR_W = `DPM_ADDR_W
) (
    // clock and resets
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic master_clear_n,
    // counter control
    input wire logic counter_or_mask_sel,
    input wire logic count_clear_n,
    input wire logic addr_load_strobe_n,
    input wire logic count_advance_n,
    input wire logic [ADDR_W-1:0] addr_in,
    // results
    output logic [ADDR_W-1:0] acc_addr,
    output logic [ADDR_W-1:0] count,
    output logic [ADDR_W-1:0] mask,
    output logic wrap_flag_n
);
    import dpm_pkg::*;

    dpm_op_t op;
    logic [ADDR_W-1:0] next_count;
    logic [ADDR_W-1:0] next_mask;
    logic next_wrap_flag_n;
    logic [ADDR_W-1:0] inc_val;

    // strobe low: this cycle uses the pin address
    assign acc_addr = addr_load_strobe_n ? count : addr_in;

    // ************************************************************
    // operation decode
    // ************************************************************
    always_comb begin
        op = DPM_OP_HOLD;
        if (counter_or_mask_sel) begin
            if (!count_clear_n) begin
                op = DPM_OP_CLEAR;
            end else if (!addr_load_strobe_n) begin
                op = DPM_OP_LOAD;
            end else if (!count_advance_n) begin
                op = DPM_OP_INC;
            end
        end else begin
            if (!count_clear_n) begin
                op = DPM_OP_MASK_CLEAR;
            end else if (!addr_load_strobe_n && !count_advance_n) begin
                op = DPM_OP_MASK_LOAD;
            end
        end
    end

    // masked bits forced to one so the carry skips them
    assign inc_val = (((count | ~mask) + 1'b1) & mask) | (count & ~mask);

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        next_count = count;
        next_mask = mask;
        next_wrap_flag_n = wrap_flag_n;
        case (op)
            DPM_OP_CLEAR: begin
                next_count = count & ~mask;
                next_wrap_flag_n = 1'b1;
            end
            DPM_OP_LOAD: begin
                next_count = addr_in;
                next_wrap_flag_n = 1'b1;
            end
            DPM_OP_INC: begin
                next_count = inc_val;
                next_wrap_flag_n = !((inc_val & mask) == mask);
            end
            DPM_OP_MASK_CLEAR: begin
                next_mask = {ADDR_W{`DPM_MASK_RST_VAL}};
            end
            DPM_OP_MASK_LOAD: begin
                next_mask = addr_in;
            end
            DPM_OP_HOLD: begin
                next_count = count;
            end
            default: begin
                next_count = count;
            end
        endcase
    end

    // master clear acts without the clock
    always_ff @(posedge mclk or negedge master_clear_n) begin
        if (!master_clear_n) begin
            count <= {ADDR_W{`DPM_CNT_RST_VAL}};
            mask <= {ADDR_W{`DPM_MASK_RST_VAL}};
            wrap_flag_n <= `DPM_FLAG_RST_VAL;
        end else if (!rst_b) begin
            count <= {ADDR_W{`DPM_CNT_RST_VAL}};
            mask <= {ADDR_W{`DPM_MASK_RST_VAL}};
            wrap_flag_n <= `DPM_FLAG_RST_VAL;
        end else begin
            count <= next_count;
            mask <= next_mask;
            wrap_flag_n <= next_wrap_flag_n;
        end
    end

endmodule

// ---- rtl/dpm_top.sv ----
// dual-port ram array with per-port burst counters and mailbox flags
`timescale 1ns/100ps
`include "dpm_cfg.svh"

// What this block does
// - strobe low uses pin address for the access and loads the counter.
// - count advance low increments the counter every rising clock edge.
// - strobe or counter clear low stops incrementing.
// - counter clear zeroes only the unmasked counter bits.
// - counter clear works whatever strobe and count advance do.
// - select low steers control operations to the mask register.
// - select high hides the mask; counter follows its controls.
// - data pins drive read data only while output enable is low.
// - writing the other port's mailbox pulls its mailbox flag low.
// - reading one's own mailbox returns its mailbox flag high.
// - the two top addresses are the mailbox locations.
// - wrap flag goes low when increment makes unmasked bits all ones.
// - read-not-write low writes, high reads.
// - each byte select enables only its own lane.
// - master clear is asynchronous and resets both ports.
// - port selected only with low select low and high select high.
// - top address is right mailbox, the one below is left mailbox.
// - master clear zeroes counters, sets masks and flags to ones.
// - counter and mask work regardless of chip selects.
// - counter controls are sampled on the port clock rising edge.
module dpm_top #(
    parameter int ADDR_W = `DPM_ADDR_W,
    parameter int DATA_W = `DPM_DATA_W,
    parameter int LANES = `DPM_LANES
) (
    // clock and resets
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic master_clear_n,
    // left port control
    input wire logic [ADDR_W-1:0] l_addr,
    input wire logic l_addr_load_strobe_n,
    input wire logic l_chip_sel_low_active,
    input wire logic l_chip_sel_high_active,
    input wire logic l_count_advance_n,
    input wire logic l_count_clear_n,
    input wire logic l_counter_or_mask_sel,
    input wire logic l_rd_wr_n,
    input wire logic [LANES-1:0] l_byte_lane_sel_n,
    input wire logic l_out_en_n,
    // left port data
    input wire logic [DATA_W-1:0] l_dq_in,
    output logic [DATA_W-1:0] l_dq_out,
    output logic [DATA_W-1:0] l_dq_oe,
    // left port flags
    output logic l_mbox_flag_n,
    output logic l_wrap_flag_n,
    // right port control
    input wire logic [ADDR_W-1:0] r_addr,
    input wire logic r_addr_load_strobe_n,
    input wire logic r_chip_sel_low_active,
    input wire logic r_chip_sel_high_active,
    input wire logic r_count_advance_n,
    input wire logic r_count_clear_n,
    input wire logic r_counter_or_mask_sel,
    input wire logic r_rd_wr_n,
    input wire logic [LANES-1:0] r_byte_lane_sel_n,
    input wire logic r_out_en_n,
    // right port data
    input wire logic [DATA_W-1:0] r_dq_in,
    output logic [DATA_W-1:0] r_dq_out,
    output logic [DATA_W-1:0] r_dq_oe,
    // right port flags
    output logic r_mbox_flag_n,
    output logic r_wrap_flag_n
);
    import dpm_pkg::*;

    localparam int LANE_W = DATA_W / LANES;
    localparam int DEPTH = 1 << ADDR_W;
    localparam logic [ADDR_W-1:0] MBOX_R =
        ADDR_W'(DEPTH - `DPM_MBOX_R_OFS);
    localparam logic [ADDR_W-1:0] MBOX_L =
        ADDR_W'(DEPTH - `DPM_MBOX_L_OFS);

    logic [DATA_W-1:0] mem [DEPTH];
    logic [ADDR_W-1:0] l_acc;
    logic [ADDR_W-1:0] r_acc;
    logic l_sel;
    logic r_sel;
    logic l_lane_any;
    logic r_lane_any;
    logic l_wr;
    logic r_wr;
    logic l_rd;
    logic r_rd;
    logic [DATA_W-1:0] l_lane_bits;
    logic [DATA_W-1:0] r_lane_bits;
    logic [DATA_W-1:0] l_rd_lanes;
    logic [DATA_W-1:0] r_rd_lanes;
    logic [DATA_W-1:0] next_l_rd_lanes;
    logic [DATA_W-1:0] next_r_rd_lanes;
    logic [DATA_W-1:0] next_l_dq_out;
    logic [DATA_W-1:0] next_r_dq_out;
    logic next_l_mbox_flag_n;
    logic next_r_mbox_flag_n;

    // ************************************************************
    // per-port counters
    // ************************************************************
    // counters ignore the chip selects entirely
    dpm_port #(.ADDR_W(ADDR_W)) u_left (
        .mclk(mclk),
        .rst_b(rst_b),
        .master_clear_n(master_clear_n),
        .counter_or_mask_sel(l_counter_or_mask_sel),
        .count_clear_n(l_count_clear_n),
        .addr_load_strobe_n(l_addr_load_strobe_n),
        .count_advance_n(l_count_advance_n),
        .addr_in(l_addr),
        .acc_addr(l_acc),
        .count(),
        .mask(),
        .wrap_flag_n(l_wrap_flag_n)
    );

    dpm_port #(.ADDR_W(ADDR_W)) u_right (
        .mclk(mclk),
        .rst_b(rst_b),
        .master_clear_n(master_clear_n),
        .counter_or_mask_sel(r_counter_or_mask_sel),
        .count_clear_n(r_count_clear_n),
        .addr_load_strobe_n(r_addr_load_strobe_n),
        .count_advance_n(r_count_advance_n),
        .addr_in(r_addr),
        .acc_addr(r_acc),
        .count(),
        .mask(),
        .wrap_flag_n(r_wrap_flag_n)
    );

    // ************************************************************
    // access decode
    // ************************************************************
    assign l_sel = !l_chip_sel_low_active && l_chip_sel_high_active;
    assign r_sel = !r_chip_sel_low_active && r_chip_sel_high_active;
    assign l_lane_any = !(&l_byte_lane_sel_n);
    assign r_lane_any = !(&r_byte_lane_sel_n);
    assign l_wr = l_sel && !l_rd_wr_n && l_lane_any;
    assign r_wr = r_sel && !r_rd_wr_n && r_lane_any;
    assign l_rd = l_sel && l_rd_wr_n && l_lane_any;
    assign r_rd = r_sel && r_rd_wr_n && r_lane_any;

    // expand active-low lane selects to one bit per data bit
    always_comb begin
        l_lane_bits = '0;
        r_lane_bits = '0;
        for (int i = 0; i < LANES; i++) begin
            l_lane_bits[i*LANE_W +: LANE_W] = {LANE_W{!l_byte_lane_sel_n[i]}};
            r_lane_bits[i*LANE_W +: LANE_W] = {LANE_W{!r_byte_lane_sel_n[i]}};
        end
    end

    // ************************************************************
    // array
    // ************************************************************
    // both ports may write in one cycle; right lands last on a
    // same-address clash, which is undefined for the user anyway
    always_ff @(posedge mclk) begin
        if (l_wr) begin
            mem[l_acc] <= (mem[l_acc] & ~l_lane_bits) |
                          (l_dq_in & l_lane_bits);
        end
        if (r_wr) begin
            mem[r_acc] <= (mem[r_acc] & ~r_lane_bits) |
                          (r_dq_in & r_lane_bits);
        end
    end

    // ************************************************************
    // read data and mailbox flags
    // ************************************************************
    always_comb begin
        next_l_dq_out = l_dq_out;
        next_r_dq_out = r_dq_out;
        next_l_rd_lanes = '0;
        next_r_rd_lanes = '0;
        if (l_rd) begin
            next_l_dq_out = mem[l_acc];
            next_l_rd_lanes = l_lane_bits;
        end
        if (r_rd) begin
            next_r_dq_out = mem[r_acc];
            next_r_rd_lanes = r_lane_bits;
        end
        // set beats clear when both land together
        next_r_mbox_flag_n = r_mbox_flag_n;
        if (r_rd && r_acc == MBOX_R) begin
            next_r_mbox_flag_n = 1'b1;
        end
        if (l_wr && l_acc == MBOX_R) begin
            next_r_mbox_flag_n = 1'b0;
        end
        next_l_mbox_flag_n = l_mbox_flag_n;
        if (l_rd && l_acc == MBOX_L) begin
            next_l_mbox_flag_n = 1'b1;
        end
        if (r_wr && r_acc == MBOX_L) begin
            next_l_mbox_flag_n = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge master_clear_n) begin
        if (!master_clear_n) begin
            l_mbox_flag_n <= `DPM_FLAG_RST_VAL;
            r_mbox_flag_n <= `DPM_FLAG_RST_VAL;
            l_dq_out <= '0;
            r_dq_out <= '0;
            l_rd_lanes <= '0;
            r_rd_lanes <= '0;
        end else if (!rst_b) begin
            l_mbox_flag_n <= `DPM_FLAG_RST_VAL;
            r_mbox_flag_n <= `DPM_FLAG_RST_VAL;
            l_dq_out <= '0;
            r_dq_out <= '0;
            l_rd_lanes <= '0;
            r_rd_lanes <= '0;
        end else begin
            l_mbox_flag_n <= next_l_mbox_flag_n;
            r_mbox_flag_n <= next_r_mbox_flag_n;
            l_dq_out <= next_l_dq_out;
            r_dq_out <= next_r_dq_out;
            l_rd_lanes <= next_l_rd_lanes;
            r_rd_lanes <= next_r_rd_lanes;
        end
    end

    // output enable is asynchronous: gates the registered read lanes
    assign l_dq_oe = l_out_en_n ? '0 : l_rd_lanes;
    assign r_dq_oe = r_out_en_n ? '0 : r_rd_lanes;

endmodule

// ---- tb/dpm_host_pins.sv ----
// far-side bus masters as seen on the two data buses
`timescale 1ns/100ps
module dpm_host_pins (
    // clock
    input wire logic mclk,
    // device side and host side
    input wire logic [35:0] l_q, l_oe, r_q, r_oe, l_d, r_d,
    input wire logic l_en, r_en,
    // resolved pins
    output logic [35:0] l_pin, r_pin
);
    logic [35:0] l_last = '0;
    logic [35:0] r_last = '0;
    // released bits toggle so a stale value never reads as a match
    always_ff @(posedge mclk) begin
        l_last <= l_pin;
        r_last <= r_pin;
    end
    assign l_pin = (l_oe & l_q) | (~l_oe & (l_en ? l_d : ~l_last));
    assign r_pin = (r_oe & r_q) | (~r_oe & (r_en ? r_d : ~r_last));
endmodule

// ---- tb/dpm_top_chk.sv ----
// port checker for the dual-port ram top
`timescale 1ns/100ps
module dpm_top_chk #(
    parameter int ADDR_W = 17,
    parameter int DATA_W = 36,
    parameter int LANES = 4
) (
    // clock and resets
    input wire logic mclk, rst_b, master_clear_n,
    // watched inputs
    input wire logic [ADDR_W-1:0] l_addr, r_addr,
    input wire logic l_addr_load_strobe_n, r_addr_load_strobe_n,
    input wire logic l_chip_sel_low_active, l_chip_sel_high_active,
    input wire logic r_chip_sel_low_active, r_chip_sel_high_active,
    input wire logic l_rd_wr_n, r_rd_wr_n, l_out_en_n,
    input wire logic [LANES-1:0] l_byte_lane_sel_n, r_byte_lane_sel_n,
    input wire logic l_count_clear_n, l_count_advance_n,
    input wire logic l_counter_or_mask_sel,
    // watched outputs
    input wire logic [DATA_W-1:0] l_dq_oe,
    input wire logic l_mbox_flag_n, r_mbox_flag_n, l_wrap_flag_n
);
    // ****************
    // access decode
    // ****************
    wire l_sel = !l_chip_sel_low_active && l_chip_sel_high_active
        && l_byte_lane_sel_n != '1;
    wire r_sel = !r_chip_sel_low_active && r_chip_sel_high_active
        && r_byte_lane_sel_n != '1;
    // counter-addressed mailbox hits are invisible here, so pins only
    wire l_wtop = l_sel && !l_rd_wr_n && !l_addr_load_strobe_n
        && l_addr == '1;
    wire r_rtop = r_sel && r_rd_wr_n && !r_addr_load_strobe_n
        && r_addr == '1;
    wire l_hold = l_counter_or_mask_sel && l_count_clear_n
        && l_addr_load_strobe_n && l_count_advance_n;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b || !master_clear_n);
    oe_gate_a: assert property (l_out_en_n |-> l_dq_oe == '0)
        else $error("data driven with output enable high");
    desel_quiet_a: assert property (!l_sel |=> l_dq_oe == '0)
        else $error("data driven after unselected cycle");
    read_drive_a: assert property (l_sel && l_rd_wr_n ##1 !l_out_en_n
        |-> l_dq_oe != '0) else $error("read not driven");
    write_quiet_a: assert property (l_sel && !l_rd_wr_n |=> l_dq_oe == '0)
        else $error("data driven after write");
    mbox_set_a: assert property (l_wtop |=> !r_mbox_flag_n)
        else $error("right mailbox flag not set");
    mbox_clear_a: assert property (r_rtop && !l_wtop |=> r_mbox_flag_n)
        else $error("right mailbox flag not cleared");
    wrap_clear_a: assert property (l_counter_or_mask_sel
        && !(l_count_clear_n && l_addr_load_strobe_n) |=> l_wrap_flag_n)
        else $error("wrap flag low after load or clear");
    wrap_hold_a: assert property (l_hold |=> $stable(l_wrap_flag_n))
        else $error("wrap flag moved on hold");
    mclr_flags_a: assert property (disable iff (!rst_b)
        !master_clear_n |-> l_mbox_flag_n && r_mbox_flag_n && l_wrap_flag_n)
        else $error("flags not high under master clear");
    cover property (!r_mbox_flag_n);
    cover property (!l_wrap_flag_n);
    cover property (l_dq_oe == '1);
endmodule
bind dpm_top dpm_top_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W),
    .LANES(LANES)) dpm_top_chk_inst (.*);

// ---- tb/dpm_top_tb.sv ----
// self-checking bench for the dual-port ram top
`timescale 1ns/100ps
module dpm_top_tb;
    import dpm_pkg::*;
    // control byte: oe_n, cs_low, cs_high, rw_n, cms, clr_n, ads_n, adv_n
    localparam logic [7:0] IDL = 8'h5F, WR = 8'h25, RD = 8'h35;
    localparam logic [7:0] HRD = 8'h37, LD = 8'h5D, INC = 8'h5E;
    localparam logic [7:0] CLR = 8'h58, MLD = 8'h54, MCLR = 8'h53;
    localparam logic [16:0] TOP = 17'h1FFFF;
    localparam logic [35:0] D1 = 36'hA5A5A5A5A, D2 = 36'h123456789;
    logic mclk, rst_b, master_clear_n, l_mb, r_mb, l_wr, r_wr;
    logic [7:0] lc, rc;
    logic [16:0] l_a, r_a;
    logic [35:0] l_d, r_d, l_pin, r_pin, l_q, r_q, l_oe, r_oe;
    logic [3:0] l_ln, r_ln;
    int err_count, check_count;
    dpm_top dpm_top_inst (.mclk(mclk), .rst_b(rst_b),
        .master_clear_n(master_clear_n), .l_addr(l_a),
        .l_addr_load_strobe_n(lc[1]), .l_chip_sel_low_active(lc[6]),
        .l_chip_sel_high_active(lc[5]), .l_count_advance_n(lc[0]),
        .l_count_clear_n(lc[2]), .l_counter_or_mask_sel(lc[3]),
        .l_rd_wr_n(lc[4]), .l_byte_lane_sel_n(l_ln), .l_out_en_n(lc[7]),
        .l_dq_in(l_pin), .l_dq_out(l_q), .l_dq_oe(l_oe),
        .l_mbox_flag_n(l_mb), .l_wrap_flag_n(l_wr), .r_addr(r_a),
        .r_addr_load_strobe_n(rc[1]), .r_chip_sel_low_active(rc[6]),
        .r_chip_sel_high_active(rc[5]), .r_count_advance_n(rc[0]),
        .r_count_clear_n(rc[2]), .r_counter_or_mask_sel(rc[3]),
        .r_rd_wr_n(rc[4]), .r_byte_lane_sel_n(r_ln), .r_out_en_n(rc[7]),
        .r_dq_in(r_pin), .r_dq_out(r_q), .r_dq_oe(r_oe),
        .r_mbox_flag_n(r_mb), .r_wrap_flag_n(r_wr));
    dpm_host_pins dpm_host_pins_inst (.mclk(mclk), .l_q(l_q), .l_oe(l_oe),
        .r_q(r_q), .r_oe(r_oe), .l_d(l_d), .r_d(r_d), .l_en(!lc[4]),
        .r_en(!rc[4]), .l_pin(l_pin), .r_pin(r_pin));
    // ****************
    // bus tasks
    // ****************
    // one edge per call; the other port idles
    task automatic cyc(input bit p, input logic [7:0] c,
            input logic [16:0] a, input logic [35:0] d, input logic [3:0] n);
        @(negedge mclk);
        lc = p ? IDL : c;
        rc = p ? c : IDL;
        l_a = a;
        r_a = a;
        l_d = d;
        r_d = d;
        l_ln = n;
        r_ln = n;
    endtask
    task automatic tk;
        @(posedge mclk);
        #1;
    endtask
    task automatic chk(input string s, input logic [35:0] e, v);
        check_count++;
        if (v !== e) begin
            err_count++;
            $display("[ERR] %s exp %h got %h", s, e, v);
        end
    endtask
    task automatic rd(input bit p, input logic [7:0] c, input logic [16:0] a,
            input logic [3:0] n, input logic [35:0] e, m);
        cyc(p, c, a, '0, n);
        tk();
        chk("oe", m, p ? r_oe : l_oe);
        chk("pin", e & m, (p ? r_pin : l_pin) & m);
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic s_data;
        cyc(0, WR, 17'hA, D1, 4'h0);
        cyc(0, WR, 17'hA, D2, 4'hE);
        cyc(0, 8'h0D, 17'hA, D2, 4'h0);
        cyc(0, 8'h65, 17'hA, D2, 4'h0);
        cyc(0, WR, 17'hA, D2, 4'hF);
        rd(1, RD, 17'hA, 4'h0, {D1[35:9], D2[8:0]}, '1);
        rd(1, RD, 17'hA, 4'hD, {D1[35:9], D2[8:0]}, 36'h00003FE00);
        rd(1, 8'hB5, 17'hA, 4'h0, '0, '0);
    endtask
    task automatic s_count;
        for (int i = 0; i < 4; i++) cyc(0, WR, 17'(i), 36'(i), 4'h0);
        cyc(0, 8'h5C, 17'h1, '0, 4'hF);
        cyc(0, INC, '0, '0, 4'hF);
        cyc(0, INC, '0, '0, 4'hF);
        rd(0, HRD, '0, 4'h0, 36'h3, '1);
        cyc(0, MLD, 17'h1, '0, 4'hF);
        cyc(0, LD, 17'h2, '0, 4'hF);
        cyc(0, INC, '0, '0, 4'hF);
        tk();
        chk("wrap", 36'h0, l_wr);
        rd(0, HRD, '0, 4'h0, 36'h3, '1);
        cyc(0, INC, '0, '0, 4'hF);
        tk();
        chk("wrap", 36'h1, l_wr);
        rd(0, HRD, '0, 4'h0, 36'h2, '1);
        cyc(0, LD, 17'h3, '0, 4'hF);
        cyc(0, CLR, 17'h1, '0, 4'hF);
        rd(0, HRD, '0, 4'h0, 36'h2, '1);
        cyc(0, MCLR, '0, '0, 4'hF);
        cyc(0, CLR, 17'h1, '0, 4'hF);
        rd(0, HRD, '0, 4'h0, 36'h0, '1);
    endtask
    task automatic s_mbox;
        cyc(0, WR, TOP, D1, 4'hF);
        tk();
        chk("r_mb", 36'h1, r_mb);
        cyc(0, WR, TOP, D1, 4'h0);
        tk();
        chk("r_mb", 36'h0, r_mb);
        chk("l_mb", 36'h1, l_mb);
        cyc(1, RD, TOP - 17'h1, '0, 4'h0);
        tk();
        chk("r_mb", 36'h0, r_mb);
        cyc(1, RD, TOP, '0, 4'h0);
        tk();
        chk("r_mb", 36'h1, r_mb);
        cyc(1, WR, TOP - 17'h1, D2, 4'h0);
        tk();
        chk("l_mb", 36'h0, l_mb);
        cyc(1, WR, TOP, D2, 4'h0);
        tk();
        chk("r_mb", 36'h1, r_mb);
        cyc(0, RD, TOP - 17'h1, '0, 4'h0);
        tk();
        chk("l_mb", 36'h1, l_mb);
    endtask
    task automatic s_mclr;
        cyc(0, WR, TOP, D1, 4'h0);
        cyc(0, LD, TOP - 17'h1, '0, 4'hF);
        cyc(0, INC, '0, '0, 4'hF);
        tk();
        chk("wrap", 36'h0, l_wr);
        cyc(1, LD, TOP - 17'h1, '0, 4'hF);
        cyc(1, INC, '0, '0, 4'hF);
        tk();
        chk("r_wrap", 36'h0, r_wr);
        cyc(0, IDL, '0, '0, 4'hF);
        master_clear_n = 1'b0;
        #2;
        chk("r_mb", 36'h1, r_mb);
        chk("wrap", 36'h1, l_wr);
        chk("r_wrap", 36'h1, r_wr);
        @(negedge mclk);
        master_clear_n = 1'b1;
        cyc(0, INC, '0, '0, 4'hF);
        rd(0, HRD, '0, 4'h0, 36'h1, '1);
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    initial begin
        #40000;
        err_count++;
        final_report();
    end
    initial begin
        rst_b = 1'b0;
        master_clear_n = 1'b0;
        {lc, rc, l_a, r_a, l_d, r_d} = {IDL, IDL, 106'h0};
        {l_ln, r_ln} = 8'hFF;
        err_count = 0;
        check_count = 0;
        repeat (4) @(negedge mclk);
        rst_b = 1'b1;
        master_clear_n = 1'b1;
        s_data();
        s_count();
        s_mbox();
        s_mclr();
        final_report();
    end
endmodule
